/* shared/dcpol_pkg.sv */
// package: register map, field layout and command carrier types for the class/ecc policy block
package dcpol_pkg;

  // ******************************
  // register offsets (byte addresses)
  // ******************************
  localparam logic [4:0] OFS_PRIO_MAP   = 5'h00;
  localparam logic [4:0] OFS_CLASS1_MAP = 5'h04;
  localparam logic [4:0] OFS_CLASS2_MAP = 5'h08;
  localparam logic [4:0] OFS_ECC_CTRL   = 5'h0c;
  localparam logic [4:0] OFS_RANGE_A    = 5'h10;
  localparam logic [4:0] OFS_RANGE_B    = 5'h14;

  // ******************************
  // field positions and masks
  // ******************************
  localparam int          MAP_EN_BIT      = 31;
  localparam logic [31:0] PRIO_WR_MASK    = 32'h8000_ffff;
  localparam logic [31:0] ECC_WR_MASK     = 32'hf000_0003;
  localparam int          ECC_EN_BIT      = 31;
  localparam int          ECC_POL_BIT     = 30;
  localparam int          ECC_VERIFY_BIT  = 29;
  localparam int          ECC_MERGE_BIT   = 28;
  localparam int          ECC_RNG_B_BIT   = 1;
  localparam int          ECC_RNG_A_BIT   = 0;
  localparam int          ID_A_LSB        = 23;
  localparam int          ID_B_LSB        = 12;
  localparam int          ID_C_LSB        = 2;
  localparam int          MSK_A_LSB       = 20;
  localparam int          MSK_B_LSB       = 10;
  localparam int          MSK_C_LSB       = 0;
  localparam logic [31:0] REG_RESET       = 32'h0000_0000;
  localparam logic [1:0]  CLASS_ONE_CODE  = 2'h1;
  localparam logic [1:0]  CLASS_TWO_CODE  = 2'h2;

  // ******************************
  // command carriers
  // ******************************
  typedef struct packed {
    logic        valid;
    logic        write;
    logic        partial;
    logic [2:0]  prio;
    logic [7:0]  master;
    logic [32:0] addr;
  } dcpol_cmd_type;

  typedef struct packed {
    logic        valid;
    logic [1:0]  cos;
    logic        ecc_calc;
    logic        ecc_verify;
    logic        rmw;
  } dcpol_policy_type;

endpackage

/* hw/dcpol_id_match.sv */
// one master-identifier compare with low-bit masking
`timescale 1ns/100ps
module dcpol_id_match (
  input  wire logic [7:0] id_i,
  input  wire logic [2:0] mask_i,
  input  wire logic [7:0] master_i,
  output logic            hit_o
);
  import dcpol_pkg::*;

  wire logic [7:0] care;

  assign care = (mask_i == 3'h0) ? 8'hff :
                (mask_i == 3'h1) ? 8'hfe :
                (mask_i == 3'h2) ? 8'hfc : 8'hf8;
  assign hit_o = ((id_i ^ master_i) & care) == 8'h00;
endmodule

/* hw/dcpol_range_check.sv */
// inclusive address range test on the upper sixteen address bits
`timescale 1ns/100ps
module dcpol_range_check (
  input  wire logic [31:0] bounds_i,
  input  wire logic        on_i,
  input  wire logic [32:0] addr_i,
  output logic             inside_o
);
  import dcpol_pkg::*;

  wire logic [15:0] page;

  assign page     = addr_i[32:17];
  assign inside_o = on_i && (page >= bounds_i[15:0]) && (page <= bounds_i[31:16]);
endmodule

/* hw/dcpol_top.sv */
// class-of-service and ecc policy for sdram commands, with wishbone register file
//
// The implementer's own choices: the register offsets and the Wishbone interface to the registers.
`timescale 1ns/100ps
module dcpol_top (
  input  wire logic                     core_clk_i,
  input  wire logic                     rst_i,
  input  wire logic                     wb_cyc_i,
  input  wire logic                     wb_stb_i,
  input  wire logic                     wb_we_i,
  input  wire logic [4:0]               wb_adr_i,
  input  wire logic [3:0]               wb_sel_i,
  input  wire logic [31:0]              wb_dat_i,
  output logic      [31:0]              wb_dat_o,
  output logic                          wb_ack_o,
  output logic                          wb_err_o,
  input  wire dcpol_pkg::dcpol_cmd_type cmd_i,
  output dcpol_pkg::dcpol_policy_type   policy_o,
  output logic                          ecc_init_start_o
);
  import dcpol_pkg::*;

  // ******************************
  // registers and bus decode
  // ******************************
  logic [31:0] prio_class_map;
  logic [31:0] master_class_one_map;
  logic [31:0] master_class_two_map;
  logic [31:0] ecc_control;
  logic [31:0] ecc_range_a_bounds;
  logic [31:0] ecc_range_b_bounds;
  logic        ack;

  wire logic        req     = wb_cyc_i && wb_stb_i && !ack && !wb_err_o;
  wire logic        sel_p   = wb_adr_i == OFS_PRIO_MAP;
  wire logic        sel_1   = wb_adr_i == OFS_CLASS1_MAP;
  wire logic        sel_2   = wb_adr_i == OFS_CLASS2_MAP;
  wire logic        sel_e   = wb_adr_i == OFS_ECC_CTRL;
  wire logic        sel_a   = wb_adr_i == OFS_RANGE_A;
  wire logic        sel_b   = wb_adr_i == OFS_RANGE_B;
  wire logic        mapped  = sel_p | sel_1 | sel_2 | sel_e | sel_a | sel_b;
  wire logic        wr      = req && wb_we_i && mapped;
  wire logic [31:0] lanes   = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
                               {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  wire logic [31:0] rd_mux  = sel_p ? prio_class_map :
                              sel_1 ? master_class_one_map :
                              sel_2 ? master_class_two_map :
                              sel_e ? ecc_control :
                              sel_a ? ecc_range_a_bounds :
                              sel_b ? ecc_range_b_bounds : 32'h0000_0000;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wmask);
    merge = (old & ~(lanes & wmask)) | (wb_dat_i & lanes & wmask);
  endfunction

  // single-cycle answer: ack or err one edge after the request is seen
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ack      <= 1'b0;
      wb_err_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      ack      <= req && mapped;
      wb_err_o <= req && !mapped;
      wb_dat_o <= (req && !wb_we_i && mapped) ? rd_mux : wb_dat_o;
    end
  end
  assign wb_ack_o = ack;

  // write masks keep reserved bits at zero
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      prio_class_map       <= REG_RESET;
      master_class_one_map <= REG_RESET;
      master_class_two_map <= REG_RESET;
      ecc_control          <= REG_RESET;
      ecc_range_a_bounds   <= REG_RESET;
      ecc_range_b_bounds   <= REG_RESET;
    end else if (wr) begin
      if (sel_p) prio_class_map <= merge(prio_class_map, PRIO_WR_MASK);
      if (sel_1) master_class_one_map <= merge(master_class_one_map, 32'hffff_ffff);
      if (sel_2) master_class_two_map <= merge(master_class_two_map, 32'hffff_ffff);
      if (sel_e) ecc_control <= merge(ecc_control, ECC_WR_MASK);
      if (sel_a) ecc_range_a_bounds <= merge(ecc_range_a_bounds, 32'hffff_ffff);
      if (sel_b) ecc_range_b_bounds <= merge(ecc_range_b_bounds, 32'hffff_ffff);
    end
  end

  // ******************************
  // class of service
  // ******************************
  wire logic [31:0] map_reg [2];
  assign map_reg[0] = master_class_one_map;
  assign map_reg[1] = master_class_two_map;
  wire logic [1:0] cls_hit;

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_map
      wire logic [2:0] hit;
      dcpol_id_match u_a (.id_i(map_reg[g][ID_A_LSB +: 8]), .mask_i(map_reg[g][MSK_A_LSB +: 3]),
                          .master_i(cmd_i.master), .hit_o(hit[0]));
      dcpol_id_match u_b (.id_i(map_reg[g][ID_B_LSB +: 8]),
                          .mask_i({1'b0, map_reg[g][MSK_B_LSB +: 2]}),
                          .master_i(cmd_i.master), .hit_o(hit[1]));
      dcpol_id_match u_c (.id_i(map_reg[g][ID_C_LSB +: 8]),
                          .mask_i({1'b0, map_reg[g][MSK_C_LSB +: 2]}),
                          .master_i(cmd_i.master), .hit_o(hit[2]));
      assign cls_hit[g] = map_reg[g][MAP_EN_BIT] && (|hit);
    end
  endgenerate

  wire logic [1:0] prio_field = prio_class_map[{cmd_i.prio, 1'b0} +: 2];
  // only codes 1 and 2 assign a class
  wire logic [1:0] prio_cos = (prio_class_map[MAP_EN_BIT] &&
                               (prio_field == CLASS_ONE_CODE || prio_field == CLASS_TWO_CODE))
                              ? prio_field : 2'h0;
  wire logic [1:0] next_cos = cls_hit[0] ? CLASS_ONE_CODE :
                              cls_hit[1] ? CLASS_TWO_CODE : prio_cos;

  // ******************************
  // ecc treatment
  // ******************************
  wire logic in_a;
  wire logic in_b;
  dcpol_range_check u_rng_a (.bounds_i(ecc_range_a_bounds), .on_i(ecc_control[ECC_RNG_A_BIT]),
                             .addr_i(cmd_i.addr), .inside_o(in_a));
  dcpol_range_check u_rng_b (.bounds_i(ecc_range_b_bounds), .on_i(ecc_control[ECC_RNG_B_BIT]),
                             .addr_i(cmd_i.addr), .inside_o(in_b));

  wire logic ecc_on   = ecc_control[ECC_EN_BIT];
  wire logic next_calc = ecc_on && ((in_a | in_b) == ecc_control[ECC_POL_BIT]);
  // verify on reads only with ecc on
  wire logic next_ver  = next_calc && !cmd_i.write && ecc_control[ECC_VERIFY_BIT];
  // merge partial writes only with ecc on
  wire logic next_rmw  = next_calc && cmd_i.write && cmd_i.partial && ecc_control[ECC_MERGE_BIT];

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      policy_o <= '0;
    end else begin
      policy_o.valid      <= cmd_i.valid;
      policy_o.cos        <= cmd_i.valid ? next_cos : 2'h0;
      policy_o.ecc_calc   <= cmd_i.valid && next_calc;
      policy_o.ecc_verify <= cmd_i.valid && next_ver;
      policy_o.rmw        <= cmd_i.valid && next_rmw;
    end
  end

  logic ecc_on_d;
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ecc_on_d         <= 1'b0;
      ecc_init_start_o <= 1'b0;
    end else begin
      ecc_on_d         <= ecc_on;
      ecc_init_start_o <= ecc_on && !ecc_on_d;
    end
  end

  // ******************************
  // assertions
  // ******************************
  property p_prio_off;
    @(posedge core_clk_i) disable iff (rst_i)
      (cmd_i.valid && !prio_class_map[MAP_EN_BIT] && cls_hit == 2'h0) |=> policy_o.cos == 2'h0;
  endproperty
  a_prio_off: assert property (p_prio_off) else $error("class given with map off");

  property p_prio_code;
    @(posedge core_clk_i) disable iff (rst_i)
      (cmd_i.valid && cls_hit == 2'h0 && prio_class_map[MAP_EN_BIT])
      |=> policy_o.cos == (($past(prio_field) == 2'h3) ? 2'h0 : $past(prio_field));
  endproperty
  a_prio_code: assert property (p_prio_code) else $error("priority class wrong");

  property p_reserved;
    @(posedge core_clk_i) disable iff (rst_i)
      (prio_class_map[30:16] == 15'h0000) && (ecc_control[27:2] == 26'h0000000);
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved bit set");

  property p_class1_first;
    @(posedge core_clk_i) disable iff (rst_i)
      (cmd_i.valid && cls_hit[0]) |=> policy_o.cos == CLASS_ONE_CODE;
  endproperty
  a_class1_first: assert property (p_class1_first) else $error("class 1 lost");

  property p_class2;
    @(posedge core_clk_i) disable iff (rst_i)
      (cmd_i.valid && !cls_hit[0] && cls_hit[1]) |=> policy_o.cos == CLASS_TWO_CODE;
  endproperty
  a_class2: assert property (p_class2) else $error("class 2 lost");

  sequence s_ecc_rise;
    !ecc_on ##1 ecc_on;
  endsequence
  property p_init;
    @(posedge core_clk_i) disable iff (rst_i)
      s_ecc_rise |=> ecc_init_start_o ##1 !ecc_init_start_o;
  endproperty
  a_init: assert property (p_init) else $error("init pulse missing");

  property p_ecc_off;
    @(posedge core_clk_i) disable iff (rst_i)
      !ecc_on |=> !policy_o.ecc_calc && !policy_o.ecc_verify && !policy_o.rmw;
  endproperty
  a_ecc_off: assert property (p_ecc_off) else $error("ecc action while off");

  property p_rmw;
    @(posedge core_clk_i) disable iff (rst_i)
      policy_o.rmw |-> $past(ecc_control[ECC_MERGE_BIT]) && $past(cmd_i.partial);
  endproperty
  a_rmw: assert property (p_rmw) else $error("merge without cause");

  property p_polarity;
    @(posedge core_clk_i) disable iff (rst_i)
      (cmd_i.valid && ecc_on && !in_a && !in_b && !ecc_control[ECC_POL_BIT])
      |=> policy_o.ecc_calc;
  endproperty
  a_polarity: assert property (p_polarity) else $error("ecc polarity wrong");

  property p_wb_ack;
    @(posedge core_clk_i) disable iff (rst_i)
      wb_ack_o |=> !wb_ack_o;
  endproperty
  a_wb_ack: assert property (p_wb_ack) else $error("ack held two cycles");

  property p_wb_err;
    @(posedge core_clk_i) disable iff (rst_i)
      wb_err_o |=> !wb_err_o;
  endproperty
  a_wb_err: assert property (p_wb_err) else $error("err held two cycles");

  // one answer per taken request: ack if mapped, err if not
  sequence s_bus_take;
    wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
  endsequence
  property p_wb_answer;
    @(posedge core_clk_i) disable iff (rst_i)
      s_bus_take |=> (wb_ack_o != wb_err_o) && (wb_err_o == !$past(mapped));
  endproperty
  a_wb_answer: assert property (p_wb_answer) else $error("bus answer wrong");

  property p_rd_prio;
    @(posedge core_clk_i) disable iff (rst_i)
      (req && !wb_we_i && sel_p) |=> wb_dat_o[30:16] == 15'h0000;
  endproperty
  a_rd_prio: assert property (p_rd_prio) else $error("priority reserved bits read back");

  property p_rd_ecc;
    @(posedge core_clk_i) disable iff (rst_i)
      (req && !wb_we_i && sel_e) |=> wb_dat_o[27:2] == 26'h0000000;
  endproperty
  a_rd_ecc: assert property (p_rd_ecc) else $error("ecc reserved bits read back");

  property p_wr_enable;
    @(posedge core_clk_i) disable iff (rst_i)
      (wr && sel_1 && wb_sel_i[3])
      |=> master_class_one_map[MAP_EN_BIT] == $past(wb_dat_i[MAP_EN_BIT]);
  endproperty
  a_wr_enable: assert property (p_wr_enable) else $error("class 1 enable not written");

  property p_class1_gate;
    @(posedge core_clk_i) disable iff (rst_i)
      cls_hit[0] |-> master_class_one_map[MAP_EN_BIT];
  endproperty
  a_class1_gate: assert property (p_class1_gate) else $error("class 1 hit while off");

  // mask code zero: an exact id must always hit
  property p_exact_id;
    @(posedge core_clk_i) disable iff (rst_i)
      (master_class_one_map[MAP_EN_BIT] && master_class_one_map[MSK_A_LSB +: 3] == 3'h0 &&
       cmd_i.master == master_class_one_map[ID_A_LSB +: 8]) |-> cls_hit[0];
  endproperty
  a_exact_id: assert property (p_exact_id) else $error("exact id missed");

  property p_mask3;
    @(posedge core_clk_i) disable iff (rst_i)
      (master_class_two_map[MAP_EN_BIT] && master_class_two_map[MSK_C_LSB +: 2] == 2'h3 &&
       cmd_i.master[7:3] == master_class_two_map[ID_C_LSB + 3 +: 5]) |-> cls_hit[1];
  endproperty
  a_mask3: assert property (p_mask3) else $error("masked id missed");

  property p_cos_legal;
    @(posedge core_clk_i) disable iff (rst_i)
      policy_o.cos != 2'h3;
  endproperty
  a_cos_legal: assert property (p_cos_legal) else $error("class code 3 issued");

  property p_idle_clear;
    @(posedge core_clk_i) disable iff (rst_i)
      !policy_o.valid |-> policy_o == '0;
  endproperty
  a_idle_clear: assert property (p_idle_clear) else $error("policy bits without command");

  property p_verify_read;
    @(posedge core_clk_i) disable iff (rst_i)
      policy_o.ecc_verify
      |-> policy_o.ecc_calc && $past(!cmd_i.write) && $past(ecc_control[ECC_VERIFY_BIT]);
  endproperty
  a_verify_read: assert property (p_verify_read) else $error("verify without cause");

  property p_rmw_write;
    @(posedge core_clk_i) disable iff (rst_i)
      policy_o.rmw |-> policy_o.ecc_calc && $past(cmd_i.write);
  endproperty
  a_rmw_write: assert property (p_rmw_write) else $error("merge on a read");

  property p_inside;
    @(posedge core_clk_i) disable iff (rst_i)
      (cmd_i.valid && ecc_on && (in_a || in_b) && ecc_control[ECC_POL_BIT])
      |=> policy_o.ecc_calc;
  endproperty
  a_inside: assert property (p_inside) else $error("ecc missed inside range");

  // the end value itself belongs to the range
  property p_range_end;
    @(posedge core_clk_i) disable iff (rst_i)
      (ecc_control[ECC_RNG_B_BIT] && cmd_i.addr[32:17] == ecc_range_b_bounds[31:16] &&
       ecc_range_b_bounds[15:0] <= ecc_range_b_bounds[31:16]) |-> in_b;
  endproperty
  a_range_end: assert property (p_range_end) else $error("range end excluded");

  property p_init_cause;
    @(posedge core_clk_i) disable iff (rst_i)
      ecc_init_start_o |-> $past(ecc_on) && !$past(ecc_on, 2);
  endproperty
  a_init_cause: assert property (p_init_cause) else $error("init pulse without enable");
endmodule

/* verif/dcpol_cmd_src.sv */
// partner model: a system bus master that issues one command at a time
`timescale 1ns/100ps
module dcpol_cmd_src (
  input  wire logic               core_clk_i,
  output dcpol_pkg::dcpol_cmd_type cmd_o
);
  import dcpol_pkg::*;
  initial cmd_o = '0;
  // idle fields carry the inverse of the last command, so stale data never looks current
  task automatic send(input dcpol_cmd_type c);
    @(posedge core_clk_i);
    cmd_o <= c;
    @(posedge core_clk_i);
    cmd_o <= {1'b0, ~c[$bits(c)-2:0]};
  endtask
endmodule

/* verif/tb_top.sv */
// testbench: register access, class-of-service mapping and ecc policy checks
`timescale 1ns/100ps
module tb_top;
  import dcpol_pkg::*;
  logic             core_clk_i, rst_i, cyc, stb, we, ack, err, init_o;
  logic [4:0]       adr;
  logic [3:0]       sel;
  logic [31:0]      wdat, rdat;
  dcpol_cmd_type    cmd;
  dcpol_policy_type pol;
  logic [31:0]      sh [6];
  int               fail_count, n_tests, inits;
  int               il [3] = '{ID_A_LSB, ID_B_LSB, ID_C_LSB};
  int               ml [3] = '{MSK_A_LSB, MSK_B_LSB, MSK_C_LSB};
  logic [15:0]      lut [8] = '{16'h000f, 16'h0010, 16'h0012, 16'h0013,
                                16'h002f, 16'h0030, 16'h0031, 16'h0032};

  dcpol_top u_dut (.core_clk_i(core_clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .wb_err_o(err),
    .cmd_i(cmd), .policy_o(pol), .ecc_init_start_o(init_o));
  dcpol_cmd_src u_src (.core_clk_i(core_clk_i), .cmd_o(cmd));

  initial begin
    core_clk_i = 1'b0;
    forever #5 core_clk_i = ~core_clk_i;
  end
  always @(posedge core_clk_i) if (init_o === 1'b1) inits++;

  // ****************
  // checking and bus
  // ****************
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch %s exp %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // classic wishbone cycle; waits for the answer, no latency assumed
  task automatic acc(input logic w, input logic [4:0] a, input logic [31:0] d);
    int          n;
    logic [31:0] m;
    logic        mp;
    logic [31:0] ln;
    n = 0;
    mp = a < 5'h18;
    m = a == OFS_PRIO_MAP ? PRIO_WR_MASK : a == OFS_ECC_CTRL ? ECC_WR_MASK : '1;
    @(posedge core_clk_i);
    {cyc, stb, we, adr, wdat} <= {2'b11, w, a, d};
    @(posedge core_clk_i);
    while (ack !== 1'b1 && err !== 1'b1 && n < 50) begin
      @(posedge core_clk_i);
      n++;
    end
    if (n >= 50) begin
      fail_count++;
      tally_and_finish;
    end
    chk("bus err", {31'h0, err}, {31'h0, !mp});
    if (mp && !w) chk("read", rdat, sh[a[4:2]]);
    ln = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
    if (mp && w) sh[a[4:2]] = (sh[a[4:2]] & ~(m & ln)) | (d & m & ln);
    {cyc, stb} <= 2'b00;
  endtask

  // ****************
  // expected policy
  // ****************
  function automatic logic idm(logic [7:0] id, logic [2:0] m, logic [7:0] x);
    logic [7:0] k;
    k = (m > 3) ? 8'h07 : (8'h01 << m) - 8'h01;
    return ((id ^ x) & ~k) == 8'h00;
  endfunction
  function automatic logic hit(logic [31:0] r, logic [7:0] x);
    return r[31] && (idm(r[30:23], r[22:20], x) || idm(r[19:12], {1'b0, r[11:10]}, x)
           || idm(r[9:2], {1'b0, r[1:0]}, x));
  endfunction
  function automatic logic in_rng(logic [31:0] b, logic [15:0] a);
    return a >= b[15:0] && a <= b[31:16];
  endfunction
  function automatic dcpol_policy_type expect_pol(dcpol_cmd_type c);
    dcpol_policy_type p;
    logic [1:0]       f;
    logic             ins;
    logic [31:0]      e;
    e = sh[3];
    f = sh[0][{c.prio, 1'b0} +: 2];
    ins = (e[0] && in_rng(sh[4], c.addr[32:17])) || (e[1] && in_rng(sh[5], c.addr[32:17]));
    p.valid = c.valid;
    p.cos = hit(sh[1], c.master) ? 2'h1 : hit(sh[2], c.master) ? 2'h2 :
            (sh[0][31] && (f == 2'h1 || f == 2'h2)) ? f : 2'h0;
    p.ecc_calc = e[31] && (ins == e[30]);
    p.ecc_verify = p.ecc_calc && !c.write && e[29];
    p.rmw = p.ecc_calc && c.write && c.partial && e[28];
    return p;
  endfunction

  task automatic cmdchk(input logic w, input logic pt, input logic [2:0] pr,
                        input logic [7:0] ms, input logic [32:0] ad);
    dcpol_cmd_type c;
    c = {1'b1, w, pt, pr, ms, ad};
    u_src.send(c);
    #1;
    chk("policy", 32'(pol), 32'(expect_pol(c)));
  endtask

  // ****************
  // tests
  // ****************
  initial begin
    rst_i = 1'b1;
    {cyc, stb, we, adr, wdat} = '0;
    sel = 4'hf;
    for (int i = 0; i < 6; i++) sh[i] = REG_RESET;
    repeat (6) @(posedge core_clk_i);
    rst_i <= 1'b0;
    for (int i = 0; i < 8; i++) acc(1'b0, 5'(i * 4), 32'h0);
    cmdchk(1'b0, 1'b0, 3'h0, 8'h00, 33'h0);
    acc(1'b1, 5'h18, 32'h1);
    acc(1'b1, OFS_PRIO_MAP, 32'hffff_ffff);
    acc(1'b0, OFS_PRIO_MAP, 32'h0);
    acc(1'b1, OFS_ECC_CTRL, 32'hffff_ffff);
    acc(1'b0, OFS_ECC_CTRL, 32'h0);
    acc(1'b1, OFS_ECC_CTRL, 32'h0);
    sel <= 4'h5;
    acc(1'b1, OFS_RANGE_A, 32'h1234_5678);
    sel <= 4'ha;
    acc(1'b1, OFS_RANGE_A, 32'h9abc_def0);
    sel <= 4'hf;
    acc(1'b0, OFS_RANGE_A, 32'h0);
    $display("test reset_and_reserved done");
    for (int en = 0; en < 2; en++) begin
      acc(1'b1, OFS_PRIO_MAP, {en[0], 15'h7fff, 16'h9c63});
      for (int p = 0; p < 8; p++) cmdchk(1'b0, 1'b0, 3'(p), 8'h11, 33'h0);
    end
    $display("test priority_map done");
    for (int r = 1; r < 3; r++) begin
      for (int s = 0; s < 3; s++)
        for (int m = 0; m < (s == 0 ? 8 : 4); m++) begin
          acc(1'b1, 5'(r * 4), 32'h8000_0000 | (32'h5a << il[s]) | (32'(m) << ml[s]));
          for (int k = 0; k < 16; k++) cmdchk(1'b0, 1'b0, 3'h1, 8'h5a ^ 8'(k), 33'h0);
        end
      acc(1'b1, 5'(r * 4), 32'h0);
    end
    for (int e = 0; e < 8; e++) begin
      acc(1'b1, OFS_CLASS1_MAP, {e[0], 8'h5a, 23'h0});
      acc(1'b1, OFS_CLASS2_MAP, {e[1], 8'h5a, 23'h0});
      acc(1'b1, OFS_PRIO_MAP, {e[2], 15'h0, 16'h0009});
      for (int p = 0; p < 2; p++) cmdchk(1'b0, 1'b0, 3'(p), 8'h5a, 33'h0);
    end
    $display("test master_map done");
    rst_i <= 1'b1;
    repeat (2) @(posedge core_clk_i);
    rst_i <= 1'b0;
    for (int i = 0; i < 6; i++) sh[i] = REG_RESET;
    for (int i = 0; i < 6; i++) acc(1'b0, 5'(i * 4), 32'h0);
    cmdchk(1'b1, 1'b1, 3'h0, 8'h5a, 33'h0);
    $display("test mid_reset done");
    acc(1'b1, OFS_RANGE_A, 32'h0012_0010);
    acc(1'b1, OFS_RANGE_B, 32'h0031_0030);
    for (int e = 0; e < 32; e++) begin
      acc(1'b1, OFS_ECC_CTRL, {e[4], e[3], e[2], e[2], 26'h3ff_ffff, e[1:0]});
      for (int a = 0; a < 32; a++)
        cmdchk(a[3], a[4], 3'h0, 8'h77, {lut[a[2:0]], 17'h1ffff});
    end
    acc(1'b1, OFS_ECC_CTRL, 32'h8000_0000);
    repeat (3) @(posedge core_clk_i);
    // enable rose twice; rewriting it while already set must not start again
    chk("init pulses", 32'(inits), 32'd2);
    $display("test ecc_policy done");
    tally_and_finish;
  end

  initial begin
    #100000;
    fail_count++;
    $display("watchdog expired");
    tally_and_finish;
  end
endmodule
